/* rtl/serial_consts.svh */
// Register offsets, field positions, reset values and timing counts of the serial block.
`ifndef SERIAL_CONSTS_SVH
`define SERIAL_CONSTS_SVH
`define OFF_CTRL_A     8'h00
`define OFF_CTRL_B     8'h04
`define OFF_CTRL_C     8'h08
`define OFF_STAT_A     8'h0C
`define OFF_STAT_B     8'h10
`define OFF_DATA       8'h14
`define CA_SERIAL_ON   6
`define CA_POL_FLIP    5
`define CA_CHAR9       4
`define CB_TXE_IE      7
`define CB_DONE_IE     6
`define CB_RXF_IE      5
`define CB_TX_ON       3
`define CB_RX_ON       2
`define CB_SEND_BRK    0
`define CC_NINTH       7
`define CC_TX8         6
`define SA_TBE         7
`define SA_DONE        6
`define SA_RXF         5
`define SA_OVR         3
`define SA_NOISE       2
`define SA_FRAME       1
`define SB_BRK         1
`define SB_RIP         0
`define CTRL_RESET     8'h00
`define SAMPLE_DIV_DEF 54
`define RT_PER_BIT     16
`define HUNT_ONES      2'h3
`endif

/* rtl/serial_pkg.sv */
// Types shared by the serial transmitter and receiver.
package serial_pkg;
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_PRE  = 5'b00010,
    TX_DATA = 5'b00100,
    TX_BRK  = 5'b01000,
    TX_ONE  = 5'b10000
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_HUNT  = 3'b001,
    RX_START = 3'b010,
    RX_BITS  = 3'b100
  } rx_state_t;
endpackage

/* rtl/rx_link_if.sv */
// Received character report passed from the bit recovery module to the core.
`timescale 1ns/1ps
interface rx_link_if;
  logic       done;
  logic [8:0] data;
  logic       noise;
  logic       frame;
  logic       brk;
  logic       busy;
  modport src (output done, data, noise, frame, brk, busy);
  modport dst (input done, data, noise, frame, brk, busy);
endinterface

/* rtl/rx_recover.sv */
// Receive bit recovery with 16x oversampling, start verification and noise detection.
`timescale 1ns/1ps
`include "serial_consts.svh"
module rx_recover
  import serial_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic rx_pin,
  input  wire logic en,
  input  wire logic char9,
  rx_link_if.src    lk
);
  function automatic logic maj3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction
  function automatic logic dis3(input logic [2:0] v);
    return (v != 3'b000) && (v != 3'b111);
  endfunction

  rx_state_t  st;
  logic [3:0] rt;
  logic [3:0] idx;
  logic [1:0] ones;
  logic [1:0] smp;
  logic       prev_bit;
  logic       last_s;
  logic [8:0] sh;
  logic       nz;

  wire [3:0] stop_idx = char9 ? 4'hA : 4'h9;
  wire [2:0] win      = {smp, rx_pin};
  wire       vote     = maj3(win);
  wire       is_stop  = (idx == stop_idx);
  wire       resync   = (st == RX_BITS) && !is_stop && prev_bit && last_s && !rx_pin && (rt > 4'hA);
  wire [8:0] frame_d  = char9 ? sh : {1'b0, sh[8:1]};

  assign lk.data = frame_d;
  assign lk.busy = (st != RX_HUNT);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st       <= RX_HUNT;
      rt       <= 4'h0;
      idx      <= 4'h0;
      ones     <= 2'h0;
      smp      <= 2'h0;
      prev_bit <= 1'b0;
      last_s   <= 1'b1;
      sh       <= 9'h000;
      nz       <= 1'b0;
      lk.done  <= 1'b0;
      lk.noise <= 1'b0;
      lk.frame <= 1'b0;
      lk.brk   <= 1'b0;
    end else begin
      lk.done <= 1'b0;
      if (!en) begin
        st   <= RX_HUNT;
        ones <= 2'h0;
      end else if (tick) begin
        last_s <= rx_pin;
        case (st)
          // RULE19 start hunt
          RX_HUNT: begin
            if (rx_pin) begin
              ones <= (ones == `HUNT_ONES) ? ones : ones + 2'h1;
            end else if (ones == `HUNT_ONES) begin
              st <= RX_START;
              rt <= 4'h1;
              nz <= 1'b0;
            end else begin
              ones <= 2'h0;
            end
          end
          RX_START: begin
            rt <= rt + 4'h1;
            if (rt == 4'h2 || rt == 4'h4) begin
              smp <= {smp[0], rx_pin};
            end
            // RULE20 start verification
            if (rt == 4'h6) begin
              if (win[2:1] == 2'b11 || (win[2] ^ win[1]) && rx_pin) begin
                st   <= RX_HUNT;
                ones <= 2'h0;
              end else if (win != 3'b000) begin
                nz <= 1'b1;
              end
            end
            // RULE21 late start noise
            if (rt >= 4'h7 && rt <= 4'h9 && rx_pin) begin
              nz <= 1'b1;
            end
            // RULE18 resync after start
            if (rt == 4'hF) begin
              st       <= RX_BITS;
              rt       <= 4'h0;
              idx      <= 4'h1;
              prev_bit <= 1'b0;
            end
          end
          RX_BITS: begin
            rt <= rt + 4'h1;
            if (rt == 4'h7 || rt == 4'h8) begin
              smp <= {smp[0], rx_pin};
            end
            if (rt == 4'h9) begin
              prev_bit <= vote;
              if (dis3(win)) begin
                nz <= 1'b1;
              end
              // RULE22 stop judgement
              if (is_stop) begin
                st       <= RX_HUNT;
                ones     <= vote ? `HUNT_ONES : 2'h0;
                lk.done  <= 1'b1;
                lk.noise <= nz | dis3(win);
                lk.frame <= !vote;
                // RULE9 break detect
                lk.brk   <= !vote && (frame_d == 9'h000);
              end else begin
                // RULE21 data majority
                sh <= {vote, sh[8:1]};
              end
            end
            // RULE18 resync on falling edge
            if (resync) begin
              rt  <= 4'h1;
              idx <= idx + 4'h1;
            end else if (rt == 4'hF) begin
              rt  <= 4'h0;
              idx <= idx + 4'h1;
            end
          end
          default: st <= RX_HUNT;
        endcase
      end
    end
  end
endmodule

/* rtl/serial_core.sv */
// Serial transmitter, receiver registers and AHB-Lite register slave.
//
// Overview of operation
// RULE1: each transmission sends an idle preamble, then start bit, data, stop bit; the code sends the preamble only after tx_on rises.
// RULE2: software enables serial_on, then tx_on, then writes data.
// RULE3: tx_buffer_empty clears only by status_reg_a read then data_buffer write.
// RULE4: buffer handoff sets tx_buffer_empty; with tx_empty_irq_en it raises tx_irq.
// RULE5: tx_pin idles high when no character is shifting.
// RULE6: clearing serial_on releases the tx pin and stops the receiver.
// RULE7: while send_break is set, all-zero break characters repeat at character length.
// RULE8: after send_break clears, finish the break then send at least one 1.
// RULE9: start, eight or nine zero data bits and zero stop means break.
// RULE10: break sets framing_fault, rx_full, break_seen and zeroes data and ninth_bit.
// RULE11: idle character is all ones of character length and forms the preamble.
// RULE12: tx_on cleared ends output after the character; toggling it queues idle.
// RULE13: software restores tx_on before the stop bit leaves when queueing idle.
// RULE14: output_polarity_flip inverts every level on tx_pin.
// RULE15: shift_done shows shifter and buffer empty, no break or idle; done_irq_en interrupts.
// RULE16: ninth_bit holds bit 8 in nine-bit mode, else a copy of bit 7.
// RULE17: a full character moves to data_buffer and sets rx_full; rx_full_irq_en interrupts.
// RULE18: receiver samples at sixteen ticks per bit, resyncs at start and falling edges.
// RULE19: start hunt needs a zero after three ones, then tick count starts.
// RULE20: samples 3, 5, 7 verify start; two ones reject, one one flags noise.
// RULE21: data bits take majority of samples 8, 9, 10; disagreement flags noise.
// RULE22: stop bit majority zero flags framing, disagreement flags noise.
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`include "serial_consts.svh"
module serial_core
  import serial_pkg::*;
#(
  parameter int SAMPLE_DIV = `SAMPLE_DIV_DEF
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output logic             tx_pin,
  output logic             tx_pin_oe,
  input  wire logic        rx_pin,
  output logic             tx_irq,
  output logic             rx_irq
);

  if (SAMPLE_DIV < 2 || SAMPLE_DIV > 65535) begin : g_chk
    $error("SAMPLE_DIV must be between 2 and 65535");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sample tick and bit tick dividers.

  logic [15:0] div_cnt;
  logic [3:0]  tx_rt;

  wire sample_tick = (div_cnt == 16'(SAMPLE_DIV - 1));
  wire bit_tick    = sample_tick && (tx_rt == 4'(`RT_PER_BIT - 1));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
    end else if (sample_tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_rt <= 4'h0;
    end else if (sample_tick) begin
      tx_rt <= tx_rt + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic       tx_bit8;
  logic [7:0] tx_data;
  logic [7:0] rx_data;
  logic       ninth_bit;
  logic       tx_buffer_empty;
  logic       shift_done;
  logic       rx_full;
  logic       overrun;
  logic       noise_flag;
  logic       framing_fault;
  logic       break_seen;
  logic       arm_a;
  logic       arm_b;
  rx_link_if  lk ();

  wire serial_on            = ctrl_a[`CA_SERIAL_ON];
  wire output_polarity_flip = ctrl_a[`CA_POL_FLIP];
  wire char9                = ctrl_a[`CA_CHAR9];
  wire tx_empty_irq_en      = ctrl_b[`CB_TXE_IE];
  wire done_irq_en          = ctrl_b[`CB_DONE_IE];
  wire rx_full_irq_en       = ctrl_b[`CB_RXF_IE];
  wire tx_on                = ctrl_b[`CB_TX_ON];
  wire rx_on                = ctrl_b[`CB_RX_ON];
  wire send_break           = ctrl_b[`CB_SEND_BRK];

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY, reads captured at address phase.

  logic       wr_pend;
  logic [7:0] wr_off;

  wire       ahb_go  = hsel && htrans[1] && hready;
  wire       a_map   = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
  wire [7:0] a_off   = a_map ? haddr[7:0] : 8'hFF;
  wire       rd_go   = ahb_go && !hwrite;
  wire       rd_sa   = rd_go && (a_off == `OFF_STAT_A);
  wire       rd_sb   = rd_go && (a_off == `OFF_STAT_B);
  wire       rd_dat  = rd_go && (a_off == `OFF_DATA);
  wire       we_ca   = wr_pend && (wr_off == `OFF_CTRL_A);
  wire       we_cb   = wr_pend && (wr_off == `OFF_CTRL_B);
  wire       we_cc   = wr_pend && (wr_off == `OFF_CTRL_C);
  wire       we_dat  = wr_pend && (wr_off == `OFF_DATA);
  wire [7:0] stat_a  = {tx_buffer_empty, shift_done, rx_full, 1'b0,
                        overrun, noise_flag, framing_fault, 1'b0};
  wire [7:0] stat_b  = {6'h00, break_seen, lk.busy};
  wire [7:0] ctrl_c  = {ninth_bit, tx_bit8, 6'h00};
  wire [7:0] rd_mux  = (a_off == `OFF_CTRL_A) ? ctrl_a :
                       (a_off == `OFF_CTRL_B) ? ctrl_b :
                       (a_off == `OFF_CTRL_C) ? ctrl_c :
                       (a_off == `OFF_STAT_A) ? stat_a :
                       (a_off == `OFF_STAT_B) ? stat_b :
                       (a_off == `OFF_DATA)   ? rx_data : 8'h00;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_off  <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      wr_pend <= ahb_go && hwrite;
      wr_off  <= a_off;
      if (rd_go) begin
        hrdata <= {24'h000000, rd_mux};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a  <= `CTRL_RESET;
      ctrl_b  <= `CTRL_RESET;
      tx_bit8 <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      if (we_ca) begin
        ctrl_a <= hwdata[7:0];
      end
      if (we_cb) begin
        ctrl_b <= hwdata[7:0];
      end
      if (we_cc) begin
        tx_bit8 <= hwdata[`CC_TX8];
      end
      if (we_dat) begin
        tx_data <= hwdata[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter.

  tx_state_t   tx_state;
  logic [10:0] tx_sh;
  logic [3:0]  tx_left;
  logic        preamble_due;
  logic        one_due;
  logic        tx_on_q;

  wire [3:0]  char_bits = char9 ? 4'hB : 4'hA;
  wire [10:0] data_word = char9 ? {1'b1, tx_bit8, tx_data, 1'b0} : {2'b11, tx_data, 1'b0};
  wire        tx_end    = bit_tick && (tx_left <= 4'h1);
  wire        may_load  = tx_end && serial_on;
  wire        ld_brk    = may_load && send_break;
  wire        ld_one    = may_load && !send_break && one_due;
  wire        ld_pre    = may_load && !send_break && !one_due && tx_on && preamble_due;
  wire        ld_dat    = may_load && !send_break && !one_due && tx_on && !preamble_due && !tx_buffer_empty;
  wire        tx_line   = (tx_left == 4'h0) ? 1'b1 : tx_sh[0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_on_q      <= 1'b0;
      preamble_due <= 1'b0;
      one_due      <= 1'b0;
    end else begin
      tx_on_q <= tx_on;
      // RULE12 toggle queues idle
      if (tx_on && !tx_on_q) begin
        preamble_due <= 1'b1;
      end else if (ld_pre) begin
        preamble_due <= 1'b0;
      end
      // RULE8 trailing one after break
      if (ld_brk) begin
        one_due <= 1'b1;
      end else if (ld_one) begin
        one_due <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= TX_IDLE;
      tx_sh    <= 11'h7FF;
      tx_left  <= 4'h0;
    end else if (tx_end) begin
      if (ld_brk) begin
        // RULE7 break character
        tx_state <= TX_BRK;
        tx_sh    <= 11'h000;
        tx_left  <= char_bits;
      end else if (ld_one) begin
        tx_state <= TX_ONE;
        tx_sh    <= 11'h7FF;
        tx_left  <= 4'h1;
      end else if (ld_pre) begin
        // RULE11 idle preamble
        tx_state <= TX_PRE;
        tx_sh    <= 11'h7FF;
        tx_left  <= char_bits;
      end else if (ld_dat) begin
        // RULE1 framed data
        tx_state <= TX_DATA;
        tx_sh    <= data_word;
        tx_left  <= char_bits;
      end else begin
        // RULE12 idle after character
        tx_state <= TX_IDLE;
        tx_sh    <= 11'h7FF;
        tx_left  <= 4'h0;
      end
    end else if (bit_tick) begin
      tx_sh   <= {1'b1, tx_sh[10:1]};
      tx_left <= tx_left - 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pin    <= 1'b1;
      tx_pin_oe <= 1'b0;
    end else begin
      // RULE5 idle high, RULE14 polarity
      tx_pin    <= tx_line ^ output_polarity_flip;
      // RULE6 release pin
      tx_pin_oe <= serial_on;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter flags.

  wire clr_tx = we_dat && arm_a;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_buffer_empty <= 1'b1;
      shift_done      <= 1'b1;
    end else begin
      // RULE4 handoff sets empty, RULE3 clear sequence
      if (ld_dat) begin
        tx_buffer_empty <= 1'b1;
      end else if (clr_tx) begin
        tx_buffer_empty <= 1'b0;
      end
      // RULE15 transmission complete
      shift_done <= (tx_state == TX_IDLE) && (tx_left == 4'h0) && tx_buffer_empty && !clr_tx
                    && !send_break && !one_due && !preamble_due;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receiver and receive flags.

  rx_recover u_rx (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tick  (sample_tick),
    .rx_pin(rx_pin),
    .en    (serial_on && rx_on),
    .char9 (char9),
    .lk    (lk.src)
  );

  wire clr_rx  = rd_dat && arm_a;
  wire clr_brk = rd_dat && arm_b;
  wire rx_take = lk.done && (!rx_full || clr_rx);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arm_a <= 1'b0;
      arm_b <= 1'b0;
    end else begin
      if (rd_sa) begin
        arm_a <= 1'b1;
      end else if (rd_dat || we_dat) begin
        arm_a <= 1'b0;
      end
      if (rd_sb) begin
        arm_b <= 1'b1;
      end else if (rd_dat || we_dat) begin
        arm_b <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data   <= 8'h00;
      ninth_bit <= 1'b0;
    end else if (rx_take) begin
      // RULE10 break zeroes data, RULE16 ninth bit
      rx_data   <= lk.brk ? 8'h00 : lk.data[7:0];
      ninth_bit <= lk.brk ? 1'b0 : (char9 ? lk.data[8] : lk.data[7]);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_full       <= 1'b0;
      overrun       <= 1'b0;
      noise_flag    <= 1'b0;
      framing_fault <= 1'b0;
      break_seen    <= 1'b0;
    end else begin
      // RULE17 receive full
      rx_full       <= rx_take || (rx_full && !clr_rx);
      overrun       <= (lk.done && !rx_take) || (overrun && !clr_rx);
      noise_flag    <= (rx_take && lk.noise) || (noise_flag && !clr_rx);
      // RULE22 framing, RULE10 break flags
      framing_fault <= (rx_take && lk.frame) || (framing_fault && !clr_rx);
      break_seen    <= (rx_take && lk.brk) || (break_seen && !clr_brk);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt requests.

  // RULE4 empty request, RULE15 done request
  assign tx_irq = (tx_buffer_empty && tx_empty_irq_en) || (shift_done && done_irq_en);
  // RULE17 receive request
  assign rx_irq = rx_full && rx_full_irq_en;

endmodule

/* dv/serial_core_sva.sv */
// Port-level assertions for the serial core.
`timescale 1ns/1ps
`include "serial_consts.svh"
module serial_core_sva
  import serial_pkg::*;
#(
  parameter int SAMPLE_DIV = `SAMPLE_DIV_DEF
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        tx_pin,
  input wire logic        tx_pin_oe,
  input wire logic        rx_pin,
  input wire logic        tx_irq,
  input wire logic        rx_irq
);
  localparam int BIT = 16 * SAMPLE_DIV;
  logic       wr_q, rd_q, un_q, rx_q, son, ton, brk, txe_ie, done_ie, rxf_ie;
  logic [7:0] a_q;
  int         quiet, fall, pre;
  wire        ap = hsel & htrans[1] & hready;
  wire        wa = wr_q && a_q == `OFF_CTRL_A;
  wire        wb = wr_q && a_q == `OFF_CTRL_B;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {wr_q, rd_q, un_q, son, ton, brk, txe_ie, done_ie, rxf_ie} <= '0;
      rx_q <= 1'b1;
      a_q <= 8'h00;
      quiet <= 0;
      fall <= 100 * BIT;
      pre <= 0;
    end else begin
      wr_q <= ap & hwrite;
      rd_q <= ap & ~hwrite;
      un_q <= ap & ~hwrite & (haddr > 32'h14 || haddr[1:0] != 2'h0);
      a_q <= haddr[7:0];
      rx_q <= rx_pin;
      if (wa) son <= hwdata[`CA_SERIAL_ON];
      if (wb) {txe_ie, done_ie, rxf_ie, ton, brk} <= {hwdata[7:5], hwdata[3], hwdata[0]};
      quiet <= (wr_q || ton || brk) ? 0 : (quiet < 100 * BIT ? quiet + 1 : quiet);
      fall <= (rx_q && !rx_pin) ? 0 : (fall < 100 * BIT ? fall + 1 : fall);
      if (wb && hwdata[3] && !ton && quiet >= 25 * BIT) pre <= 1;
      else if (pre != 0) pre <= (pre < 10 * BIT) ? pre + 1 : 0;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  AST_UNMAPPED_ZERO: assert property (un_q |-> hrdata == 32'h0) else $error("unmapped read not zero");
  AST_UPPER_ZERO: assert property (rd_q |-> hrdata[31:8] == 24'h0) else $error("read upper bits not zero");
  AST_OE_FOLLOWS:
    assert property (wa |-> ##[1:2] tx_pin_oe == son) else $error("pin enable lags serial_on");
  AST_OE_OFF:
    assert property (!son [*3] |-> !tx_pin_oe) else $error("pin driven while serial_on clear");
  AST_TX_IRQ_EN:
    assert property (tx_irq |-> (txe_ie || done_ie)) else $error("tx_irq without enable");
  AST_RX_IRQ_EN:
    assert property (rx_irq |-> rxf_ie) else $error("rx_irq without enable");
  AST_TX_QUIET:
    assert property (quiet >= 25 * BIT |-> $stable(tx_pin)) else $error("tx_pin moves while off");
  AST_PREAMBLE:
    assert property (pre > 1 |-> $stable(tx_pin)) else $error("preamble not idle");
  AST_RX_AFTER_EDGE:
    assert property ($rose(rx_irq) && !$past(wb) |-> fall <= 13 * BIT) else $error("rx_full with no frame");
endmodule
bind serial_core serial_core_sva #(.SAMPLE_DIV(SAMPLE_DIV)) chk (.mclk, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .tx_pin, .tx_pin_oe, .rx_pin, .tx_irq, .rx_irq);

/* dv/remote_serial.sv */
// Behavioural far-end serial device that sends on the receive line and decodes the transmit line.
`timescale 1ns/1ps
module remote_serial #(
  parameter int BIT = 32
) (
  input  wire logic       mclk,
  input  wire logic       line_in,
  input  wire logic       listen,
  output logic            line_out,
  output logic            got,
  output logic      [7:0] got_byte,
  output logic            got_stop
);
  logic       prev;
  logic [9:0] fr;
  task automatic send(input logic [7:0] d, input logic stop, input logic noisy);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < BIT; c++) begin
        @(posedge mclk);
        line_out <= f[i] ^ (noisy && i == 1 && (c == BIT / 2 + 1 || c == BIT / 2 + 2));
      end
    end
    @(posedge mclk);
    line_out <= 1'b1;
    repeat (2 * BIT) @(posedge mclk);
  endtask
  task automatic glitch(input int n);
    repeat (BIT) @(posedge mclk);
    line_out <= 1'b0;
    repeat (n) @(posedge mclk);
    line_out <= 1'b1;
  endtask
  initial begin
    line_out = 1'b1;
    {got, got_byte, got_stop} = '0;
    prev = 1'b1;
    forever begin
      @(posedge mclk);
      if (listen === 1'b1 && prev === 1'b1 && line_in === 1'b0) begin
        repeat (BIT / 2) @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
          fr[i] = line_in;
          if (i < 9) repeat (BIT) @(posedge mclk);
        end
        got_byte <= fr[8:1];
        got_stop <= fr[9];
        got <= 1'b1;
        @(posedge mclk);
        got <= 1'b0;
        while (line_in !== 1'b1) @(posedge mclk);
      end
      prev = line_in;
    end
  end
endmodule

/* dv/test_async_serial_tx_rx_datapath.sv */
// Self-checking bench for the serial core against a far-end serial model.
`timescale 1ns/1ps
`include "serial_consts.svh"
module test_async_serial_tx_rx_datapath
  import serial_pkg::*;
;
  localparam int DIV = 2;
  localparam int BIT = 16 * DIV;
  logic        mclk, rst_n, hsel, hwrite, listen, rd_dp, hreadyout, hresp;
  logic        tx_pin, tx_pin_oe, rx_pin, tx_irq, rx_irq, got, got_stop;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  got_byte, b;
  logic [31:0] haddr, hwdata, hrdata, st;
  logic [31:0] rq[$], mq[$];
  logic [8:0]  cq[$];
  int          num_errors, comparisons, seed, cyc, n_ch;
  wire         hready = hreadyout;
  wire         tx_line = tx_pin_oe ? tx_pin : 1'b1;
  serial_core #(.SAMPLE_DIV(DIV)) dut (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .tx_pin, .tx_pin_oe, .rx_pin, .tx_irq, .rx_irq);
  remote_serial #(.BIT(BIT)) far (.mclk, .line_in(tx_line), .listen, .line_out(rx_pin), .got, .got_byte,
    .got_stop);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_reg(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR hrdata expected %h seen %h", e, g);
    end
  endtask
  task automatic cmp_char(input logic [8:0] e, input logic [8:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR tx char expected %h seen %h", e, g);
    end
  endtask
  task automatic cmp_flag(input string what, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask
  // Reads queue the expected value and mask for the monitor.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) begin
      rq.push_back(d);
      mq.push_back(m);
      rd_dp <= 1'b1;
    end
    do @(posedge mclk); while (hready !== 1'b1);
    rd_dp <= 1'b0;
  endtask
  task automatic wrap_up();
    num_errors += cq.size() + rq.size();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cyc++;
    if (rd_dp === 1'b1) cmp_reg(rq.pop_front(), hrdata & mq.pop_front());
    if (got === 1'b1) begin
      n_ch++;
      cmp_char(cq.size() != 0 ? cq.pop_front() : 9'bx, {got_stop, got_byte});
    end
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    {rst_n, hsel, hwrite, rd_dp, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    listen = 1'b1;
    {num_errors, comparisons, cyc, n_ch} = '0;
    seed = 20713;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) ahb(1'b0, 32'(4 * i), i == 3 ? 32'hC0 : 32'h0, 32'hFFFF_FFFF);
    ahb(1'b1, `OFF_CTRL_A, 32'h40, 32'h0);
    repeat (26 * BIT) @(posedge mclk);
    cmp_flag("tx_pin_oe", 1'b1, tx_pin_oe);
    ahb(1'b1, `OFF_CTRL_B, 32'h88, 32'h0);
    for (int k = 0; k < 5; k++) begin
      b = 8'($random(seed));
      if (k == 2) ahb(1'b1, `OFF_CTRL_B, 32'h09, 32'h0);
      if (k == 2) cq.push_back(9'h000);
      if (k == 2) repeat (12 * BIT) @(posedge mclk);
      if (k == 2) ahb(1'b1, `OFF_CTRL_B, 32'h88, 32'h0);
      if (k == 4) break;
      if (k == 3) ahb(1'b1, `OFF_CTRL_B, 32'h80, 32'h0);
      if (k == 3) ahb(1'b1, `OFF_CTRL_B, 32'h88, 32'h0);
      ahb(1'b0, `OFF_STAT_A, 32'h80, 32'h80);
      ahb(1'b1, `OFF_DATA, {24'h0, b}, 32'h0);
      cq.push_back({1'b1, b});
      ahb(1'b0, `OFF_STAT_A, 32'h0, 32'h80);
      for (int t = 0; t < 30 * BIT && tx_irq !== 1'b1; t++) @(posedge mclk);
      cmp_flag("tx_irq", 1'b1, tx_irq);
    end
    for (int t = 0; t < 40 * BIT && n_ch < 5; t++) @(posedge mclk);
    repeat (2 * BIT) @(posedge mclk);
    ahb(1'b0, `OFF_STAT_A, 32'hC0, 32'hC0);
    ahb(1'b1, `OFF_CTRL_B, 32'h48, 32'h0);
    @(negedge mclk);
    cmp_flag("tx_irq", 1'b1, tx_irq);
    listen <= 1'b0;
    ahb(1'b1, `OFF_CTRL_A, 32'h60, 32'h0);
    repeat (3) @(negedge mclk);
    cmp_flag("tx_pin", 1'b0, tx_pin);
    ahb(1'b1, `OFF_CTRL_A, 32'h40, 32'h0);
    repeat (3) @(negedge mclk);
    cmp_flag("tx_pin", 1'b1, tx_pin);
    listen <= 1'b1;
    ahb(1'b1, `OFF_CTRL_B, 32'h24, 32'h0);
    far.glitch(3);
    repeat (12 * BIT) @(posedge mclk);
    ahb(1'b0, `OFF_STAT_A, 32'h0, 32'h20);
    for (int i = 0; i < 4; i++) begin
      b = (i == 3) ? 8'h00 : 8'($random(seed)) | 8'h01;
      st = (i == 1) ? 32'h24 : (i >= 2 ? 32'h22 : 32'h20);
      far.send(b, i < 2, i == 1);
      for (int t = 0; t < 4 * BIT && rx_irq !== 1'b1; t++) @(posedge mclk);
      @(negedge mclk);
      cmp_flag("rx_irq", 1'b1, rx_irq);
      ahb(1'b0, `OFF_CTRL_C, {24'h0, b[7], 7'h0}, 32'h80);
      if (i == 3) ahb(1'b0, `OFF_STAT_B, 32'h2, 32'h2);
      ahb(1'b0, `OFF_STAT_A, st, 32'h2E);
      ahb(1'b0, `OFF_DATA, {24'h0, b}, 32'hFF);
    end
    ahb(1'b1, `OFF_CTRL_A, 32'h0, 32'h0);
    repeat (3) @(negedge mclk);
    cmp_flag("tx_pin_oe", 1'b0, tx_pin_oe);
    wrap_up();
  end
endmodule
